/* core/mcsr_pkg.sv */
// Constants and carrier types for the core special-function register bank
package mcsr_pkg;
  localparam logic [5:0] ADDR_TIMER = 6'h01;
  localparam logic [5:0] ADDR_PCL = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_PTR = 6'h04;
  localparam logic [5:0] ADDR_PORT_A_DATA = 6'h05;
  localparam logic [5:0] ADDR_PORT_B_DATA = 6'h06;
  localparam logic [5:0] ADDR_PORT_C_DATA = 6'h07;
  localparam logic [5:0] ADDR_PWR = 6'h08;
  localparam logic [5:0] ADDR_WAKE = 6'h09;
  localparam logic [5:0] ADDR_PC_HIGH_BUFFER = 6'h0a;
  localparam int STACK_DEPTH = 5;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int OPT_CS = 5;
  localparam int OPT_SE = 4;
  localparam int OPT_PSA = 3;
  localparam int PWR_WDT = 7;
  localparam int PWR_EIS = 6;
  localparam int PWR_LVD = 5;
  localparam int PWR_ROC = 4;
  localparam logic [7:0] PWR_MASK = 8'hf0;
  localparam logic [7:0] PORT_A_DATA_MASK = 8'h0f;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [6:0] OPTION_RESET = 7'h3f;
  localparam logic [7:0] PTR_RESET = 8'hc0;

  typedef enum logic [2:0] {
    MCSR_PC_NEXT,
    MCSR_PC_JUMP,
    MCSR_PC_CALL,
    MCSR_PC_RET
  } mcsr_pc_op_t;

  // One instruction's effect on the bank, from the decoder
  typedef struct packed {
    mcsr_pc_op_t pc_op;
    logic [9:0] target;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [5:0] rd_addr;
    logic flags_c;
    logic flags_dc;
    logic flags_z;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic clear_watchdog_instr;
    logic sleep;
    logic wdt_overflow;
    logic option_wr;
    logic [6:0] option_data;
    logic clr_timer_flag;
  } mcsr_exec_t;
endpackage : mcsr_pkg

/* core/mcsr_bank.sv */
// Special-function register bank: timer, program counter and stack, status, ports
`timescale 1ns/1ns
module mcsr_bank #(
  parameter int PC_W = 11,
  parameter bit FOUR_BANKS = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire mcsr_pkg::mcsr_exec_t exec_in,
  input wire logic timer_ext_clock_pin_in,
  input wire logic [3:0] port_a_pins_in,
  input wire logic [7:0] port_b_pins_in,
  input wire logic [7:0] port_c_pins_in,
  output logic [7:0] rd_data_out,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] port_a_latch_out,
  output logic [7:0] port_b_latch_out,
  output logic [7:0] port_c_latch_out,
  output logic [7:0] status_out,
  output logic timer_overflow_flag_out,
  output logic prescaler_wdt_tick_out,
  output logic watchdog_enable_out,
  output logic low_voltage_detect_enable_out,
  output logic resistor_option_enable_out,
  output logic ext_irq_level_out,
  output logic [7:0] pin_change_wake_enable_out
);
  localparam logic [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};

  logic [7:0] timer_q, timer_d;
  logic [7:0] presc_q, presc_d;
  logic ext_prev_q, ext_prev_d;
  logic tflag_q, tflag_d;
  logic [6:0] option_q, option_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [PC_W-1:0] stack_q [mcsr_pkg::STACK_DEPTH];
  logic [PC_W-1:0] stack_d [mcsr_pkg::STACK_DEPTH];
  logic [2:0] sp_q, sp_d;
  logic [2:0] pc_high_buffer_q, pc_high_buffer_d;
  logic [7:0] status_q, status_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] pa_q, pa_d, pb_q, pb_d, pc_lat_q, pc_lat_d;
  logic [7:0] pwr_q, pwr_d;
  logic [7:0] wake_q, wake_d;
  logic [7:0] rd_q, rd_d;
  logic presc_tick;
  logic presc_hit;
  logic wdt_tick;
  logic src_tick;
  logic timer_tick;
  logic ext_edge;

  function automatic logic wr_hit(input mcsr_pkg::mcsr_exec_t e, input logic [5:0] a);
    wr_hit = e.wr_en && (e.wr_addr == a);
  endfunction : wr_hit

  // Prescaler output for a rate code: bit n toggling gives 1:2^(n+1)
  function automatic logic rate_hit(input logic [7:0] cnt, input logic [2:0] rate);
    logic [7:0] mask;
    mask = 8'hff >> (3'h7 - rate);
    rate_hit = ((cnt & mask) == mask);
  endfunction : rate_hit

  // Timer clock selection and edge detection
  always_comb
  begin
    ext_prev_d = timer_ext_clock_pin_in;
    ext_edge = option_q[mcsr_pkg::OPT_SE] ?
      (ext_prev_q && !timer_ext_clock_pin_in) :
      (!ext_prev_q && timer_ext_clock_pin_in);
    src_tick = option_q[mcsr_pkg::OPT_CS] ? ext_edge : 1'b1;
    presc_hit = rate_hit(presc_q, option_q[2:0]);
    // Watchdog divides one step less than the timer, so 1:1 at code zero
    wdt_tick = option_q[mcsr_pkg::OPT_PSA] &&
      ((option_q[2:0] == 3'h0) || rate_hit(presc_q, option_q[2:0] - 3'h1));
    presc_tick = option_q[mcsr_pkg::OPT_PSA] ? 1'b1 : src_tick;
    timer_tick = option_q[mcsr_pkg::OPT_PSA] ? src_tick : (src_tick && presc_hit);
  end

  // Timer, prescaler, overflow flag, option
  always_comb
  begin
    timer_d = timer_q;
    presc_d = presc_tick ? presc_q + 8'h01 : presc_q;
    tflag_d = tflag_q;
    option_d = exec_in.option_wr ? exec_in.option_data : option_q;
    if (timer_tick)
    begin
      timer_d = timer_q + 8'h01;
    end
    if (wr_hit(exec_in, mcsr_pkg::ADDR_TIMER))
    begin
      timer_d = exec_in.wr_data;
      if (!option_q[mcsr_pkg::OPT_PSA])
      begin
        presc_d = 8'h00;
      end
    end
    if (exec_in.clr_timer_flag)
    begin
      tflag_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (timer_tick && timer_q == 8'hff)
    begin
      tflag_d = 1'b1;
    end
  end

  // Program counter, buffer and circular stack
  always_comb
  begin
    logic [PC_W-1:0] jump_pc;
    logic [PC_W-1:0] linear;
    jump_pc = '0;
    linear = pc_q + PC_ONE;
    if (PC_W > 10)
    begin
      jump_pc = PC_W'({pc_high_buffer_q[2], exec_in.target});
    end
    else
    begin
      // Cast, not a slice: a slice above bit 9 would be out of range at full width
      jump_pc = PC_W'(exec_in.target);
    end
    pc_d = linear;
    sp_d = sp_q;
    stack_d = stack_q;
    pc_high_buffer_d = wr_hit(exec_in, mcsr_pkg::ADDR_PC_HIGH_BUFFER) ? exec_in.wr_data[2:0] : pc_high_buffer_q;
    unique case (exec_in.pc_op)
      mcsr_pkg::MCSR_PC_JUMP:
      begin
        pc_d = jump_pc;
      end
      mcsr_pkg::MCSR_PC_CALL:
      begin
        pc_d = jump_pc;
        stack_d[sp_q] = linear;
        sp_d = (sp_q == 3'(mcsr_pkg::STACK_DEPTH - 1)) ? 3'h0 : sp_q + 3'h1;
      end
      mcsr_pkg::MCSR_PC_RET:
      begin
        sp_d = (sp_q == 3'h0) ? 3'(mcsr_pkg::STACK_DEPTH - 1) : sp_q - 3'h1;
        pc_d = stack_q[sp_d];
      end
      default:
      begin
        if (wr_hit(exec_in, mcsr_pkg::ADDR_PCL))
        begin
          pc_d = PC_W'({pc_high_buffer_q, exec_in.wr_data});
        end
      end
    endcase
  end

  // Status, pointer, ports, power control, wake control
  always_comb
  begin
    status_d = status_q;
    if (wr_hit(exec_in, mcsr_pkg::ADDR_STATUS))
    begin
      status_d[7:5] = exec_in.wr_data[7:5];
      status_d[2:0] = exec_in.wr_data[2:0];
    end
    if (exec_in.flags_c)
    begin
      status_d[mcsr_pkg::ST_C] = exec_in.alu_c;
    end
    if (exec_in.flags_dc)
    begin
      status_d[mcsr_pkg::ST_DC] = exec_in.alu_dc;
    end
    if (exec_in.flags_z)
    begin
      status_d[mcsr_pkg::ST_Z] = exec_in.alu_z;
    end
    if (exec_in.clear_watchdog_instr)
    begin
      status_d[mcsr_pkg::ST_PD] = 1'b1;
      status_d[mcsr_pkg::ST_TO] = 1'b1;
    end
    else if (exec_in.sleep)
    begin
      status_d[mcsr_pkg::ST_PD] = 1'b0;
      status_d[mcsr_pkg::ST_TO] = 1'b1;
    end
    if (exec_in.wdt_overflow)
    begin
      status_d[mcsr_pkg::ST_TO] = 1'b0;
    end
    ptr_d = ptr_q;
    if (wr_hit(exec_in, mcsr_pkg::ADDR_PTR))
    begin
      ptr_d = FOUR_BANKS ? exec_in.wr_data : {2'b11, exec_in.wr_data[5:0]};
    end
    pa_d = wr_hit(exec_in, mcsr_pkg::ADDR_PORT_A_DATA) ?
      (exec_in.wr_data & mcsr_pkg::PORT_A_DATA_MASK) : pa_q;
    pb_d = wr_hit(exec_in, mcsr_pkg::ADDR_PORT_B_DATA) ? exec_in.wr_data : pb_q;
    pc_lat_d = wr_hit(exec_in, mcsr_pkg::ADDR_PORT_C_DATA) ? exec_in.wr_data : pc_lat_q;
    pwr_d = wr_hit(exec_in, mcsr_pkg::ADDR_PWR) ?
      (exec_in.wr_data & mcsr_pkg::PWR_MASK) : pwr_q;
    wake_d = wr_hit(exec_in, mcsr_pkg::ADDR_WAKE) ? exec_in.wr_data : wake_q;
  end

  // Registered read port; the upper counter bits have no address
  always_comb
  begin
    unique case (exec_in.rd_addr)
      mcsr_pkg::ADDR_TIMER: rd_d = timer_q;
      mcsr_pkg::ADDR_PCL: rd_d = pc_q[7:0];
      mcsr_pkg::ADDR_STATUS: rd_d = status_q;
      mcsr_pkg::ADDR_PTR: rd_d = ptr_q;
      mcsr_pkg::ADDR_PORT_A_DATA: rd_d = {4'h0, port_a_pins_in};
      mcsr_pkg::ADDR_PORT_B_DATA: rd_d = port_b_pins_in;
      mcsr_pkg::ADDR_PORT_C_DATA: rd_d = port_c_pins_in;
      mcsr_pkg::ADDR_PWR: rd_d = pwr_q;
      mcsr_pkg::ADDR_WAKE: rd_d = wake_q;
      mcsr_pkg::ADDR_PC_HIGH_BUFFER: rd_d = {5'h00, pc_high_buffer_q};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer_q <= 8'h00;
      presc_q <= 8'h00;
      ext_prev_q <= 1'b0;
      tflag_q <= 1'b0;
      option_q <= mcsr_pkg::OPTION_RESET;
      pc_q <= '0;
      for (int i = 0; i < mcsr_pkg::STACK_DEPTH; i++)
      begin
        stack_q[i] <= '0;
      end
      sp_q <= 3'h0;
      pc_high_buffer_q <= 3'h0;
      status_q <= mcsr_pkg::STATUS_RESET;
      ptr_q <= mcsr_pkg::PTR_RESET;
      pa_q <= 8'h00;
      pb_q <= 8'h00;
      pc_lat_q <= 8'h00;
      pwr_q <= 8'h00;
      wake_q <= 8'h00;
      rd_q <= 8'h00;
    end
    else
    begin
      timer_q <= timer_d;
      presc_q <= presc_d;
      ext_prev_q <= ext_prev_d;
      tflag_q <= tflag_d;
      option_q <= option_d;
      pc_q <= pc_d;
      stack_q <= stack_d;
      sp_q <= sp_d;
      pc_high_buffer_q <= pc_high_buffer_d;
      status_q <= status_d;
      ptr_q <= ptr_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      pc_lat_q <= pc_lat_d;
      pwr_q <= pwr_d;
      wake_q <= wake_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;
  assign pc_out = pc_q;
  assign port_a_latch_out = pa_q;
  assign port_b_latch_out = pb_q;
  assign port_c_latch_out = pc_lat_q;
  assign status_out = status_q;
  assign timer_overflow_flag_out = tflag_q;
  assign prescaler_wdt_tick_out = wdt_tick;
  assign watchdog_enable_out = pwr_q[mcsr_pkg::PWR_WDT];
  assign low_voltage_detect_enable_out = pwr_q[mcsr_pkg::PWR_LVD];
  assign resistor_option_enable_out = pwr_q[mcsr_pkg::PWR_ROC];
  // Bit 0 change path masked while it serves as interrupt pin
  assign ext_irq_level_out = pwr_q[mcsr_pkg::PWR_EIS] & port_b_pins_in[0];
  assign pin_change_wake_enable_out = {wake_q[7:1],
    wake_q[0] & ~pwr_q[mcsr_pkg::PWR_EIS]};
endmodule : mcsr_bank

/* bench/mcsr_bank_asserts.sv */
// Port-level property checker for the special-function register bank
`timescale 1ns/1ns
module mcsr_bank_asserts #(
  parameter int PC_W = 11
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire mcsr_pkg::mcsr_exec_t exec_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_pc_step;
    exec_in.pc_op == mcsr_pkg::MCSR_PC_NEXT && !exec_in.wr_en |=> pc_out == $past(pc_out) + 1'b1;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not advance by one");
  property p_jump;
    exec_in.pc_op == mcsr_pkg::MCSR_PC_JUMP |=> pc_out[9:0] == $past(exec_in.target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  property p_ret;
    exec_in.pc_op == mcsr_pkg::MCSR_PC_CALL ##1 exec_in.pc_op == mcsr_pkg::MCSR_PC_RET
      |=> pc_out == $past(pc_out, 2) + 1'b1;
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");
  property p_status_keep;
    exec_in.wr_en && exec_in.wr_addr == mcsr_pkg::ADDR_STATUS
      && !(exec_in.clear_watchdog_instr || exec_in.sleep || exec_in.wdt_overflow) |=> $stable(status_out[4:3]);
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("reset flags written");
  property p_sleep;
    exec_in.sleep && !exec_in.clear_watchdog_instr && !exec_in.wdt_overflow |=> status_out[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_wdt_ovf;
    exec_in.wdt_overflow |=> !status_out[4];
  endproperty
  a_wdt_ovf: assert property (p_wdt_ovf) else $error("timeout flag not cleared");
  property p_zero;
    exec_in.flags_z |=> status_out[2] == $past(exec_in.alu_z);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not from alu");
  property p_port_a_data_hi;
    exec_in.rd_addr == mcsr_pkg::ADDR_PORT_A_DATA |=> rd_data_out[7:4] == 4'h0;
  endproperty
  a_port_a_data_hi: assert property (p_port_a_data_hi) else $error("port a upper bits set");
  c_call_ret: cover property (p_ret);
  c_sleep: cover property (exec_in.sleep);
  c_wdt_ovf: cover property (exec_in.wdt_overflow);
endmodule : mcsr_bank_asserts

bind mcsr_bank mcsr_bank_asserts #(.PC_W(PC_W)) i_mcsr_bank_asserts (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .exec_in(exec_in),
  .rd_data_out(rd_data_out),
  .pc_out(pc_out),
  .status_out(status_out)
);

/* bench/mcsr_core_model.sv */
// Behavioural instruction source standing in for the execution logic
`timescale 1ns/1ns
module mcsr_core_model (
  input wire logic clk_in,
  output mcsr_pkg::mcsr_exec_t exec_out
);
  initial exec_out = '0;
  // One instruction per cycle, launched just after the edge and held a full cycle
  task automatic issue(input mcsr_pkg::mcsr_exec_t e);
    @(posedge clk_in);
    #2;
    exec_out = e;
  endtask : issue
endmodule : mcsr_core_model

/* bench/mcsr_bank_bench.sv */
// Self-checking bench for the special-function register bank
`timescale 1ns/1ns
module mcsr_bank_bench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ext_pin = 1'b0;
  logic [3:0] pa = 4'h0;
  logic [7:0] pb = 8'h00;
  logic [7:0] pcp = 8'h00;
  logic [31:0] lfsr = 32'h5436;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] expq[$];
  logic rd_seen = 1'b0;
  mcsr_pkg::mcsr_exec_t exec, e;
  logic [7:0] rd_data, pa_lat, pb_lat, pc_lat, status, wake;
  logic [10:0] pc;
  logic tof, wdt_en, lvd_en, roc_en, irq_lvl, wdt_tick;
  mcsr_core_model i_mcsr_core_model (.clk_in(clk_in), .exec_out(exec));
  mcsr_bank i_mcsr_bank (.clk_in(clk_in), .rst_n_in(rst_n_in), .exec_in(exec),
    .timer_ext_clock_pin_in(ext_pin), .port_a_pins_in(pa), .port_b_pins_in(pb),
    .port_c_pins_in(pcp), .rd_data_out(rd_data), .pc_out(pc), .port_a_latch_out(pa_lat),
    .port_b_latch_out(pb_lat), .port_c_latch_out(pc_lat), .status_out(status),
    .timer_overflow_flag_out(tof), .prescaler_wdt_tick_out(wdt_tick),
    .watchdog_enable_out(wdt_en),
    .low_voltage_detect_enable_out(lvd_en), .resistor_option_enable_out(roc_en),
    .ext_irq_level_out(irq_lvl), .pin_change_wake_enable_out(wake));
  initial forever #10 clk_in = ~clk_in;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic nop();
    i_mcsr_core_model.issue('0);
  endtask : nop
  // Write, or read with the expected value noted for the monitor
  task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d);
    e = '0;
    e.wr_en = w;
    e.wr_addr = a;
    e.wr_data = d;
    e.rd_addr = w ? 6'h00 : a;
    if (!w)
      expq.push_back(d);
    i_mcsr_core_model.issue(e);
  endtask : op
  task automatic br(input mcsr_pkg::mcsr_pc_op_t o, input logic [9:0] t, input logic [10:0] x);
    e = '0;
    e.pc_op = o;
    e.target = t;
    i_mcsr_core_model.issue(e);
    nop();
    chk(pc, x);
  endtask : br
  task automatic ctl(input logic [3:0] sel, input logic [6:0] opt);
    e = '0;
    {e.sleep, e.wdt_overflow, e.clear_watchdog_instr, e.clr_timer_flag} = sel;
    e.option_wr = opt != 7'h00;
    e.option_data = opt;
    i_mcsr_core_model.issue(e);
  endtask : ctl
  // Idle instructions, so a held timer write cannot keep reloading the count
  task automatic wait_tof();
    for (int i = 0; i < 8 && tof !== 1'b1; i++)
      nop();
  endtask : wait_tof
  // Read data lags its select by one cycle
  always @(posedge clk_in)
  begin
    if (rd_seen)
      chk(rd_data, expq.pop_front());
    rd_seen <= rst_n_in && exec.rd_addr != 6'h00;
  end
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge clk_in);
    #2 rst_n_in = 1'b1;
    op(0, mcsr_pkg::ADDR_STATUS, 8'h18);
    op(0, mcsr_pkg::ADDR_PTR, 8'hc0);
    op(1, mcsr_pkg::ADDR_STATUS, 8'h00);
    op(0, mcsr_pkg::ADDR_STATUS, 8'h18);
    e = '0;
    {e.wr_en, e.flags_c, e.flags_dc, e.flags_z, e.alu_z} = 5'h1f;
    e.wr_addr = mcsr_pkg::ADDR_STATUS;
    e.wr_data = 8'he3;
    i_mcsr_core_model.issue(e);
    op(0, mcsr_pkg::ADDR_STATUS, 8'hfc);
    ctl(4'h8, 7'h00);
    op(0, mcsr_pkg::ADDR_STATUS, 8'hf4);
    ctl(4'h4, 7'h00);
    op(0, mcsr_pkg::ADDR_STATUS, 8'he4);
    ctl(4'h2, 7'h00);
    op(0, mcsr_pkg::ADDR_STATUS, 8'hfc);
    $display("Status and reset flags done");
    op(1, mcsr_pkg::ADDR_PC_HIGH_BUFFER, 8'h05);
    op(1, mcsr_pkg::ADDR_PCL, 8'h34);
    nop();
    chk(pc, 11'h534);
    br(mcsr_pkg::MCSR_PC_JUMP, 10'h2aa, 11'h6aa);
    br(mcsr_pkg::MCSR_PC_CALL, 10'h011, 11'h411);
    br(mcsr_pkg::MCSR_PC_RET, 10'h000, 11'h6ac);
    e = '0;
    e.pc_op = mcsr_pkg::MCSR_PC_CALL;
    e.target = 10'h155;
    i_mcsr_core_model.issue(e);
    e.pc_op = mcsr_pkg::MCSR_PC_RET;
    i_mcsr_core_model.issue(e);
    nop();
    chk(pc, 11'h6ae);
    $display("Program counter done");
    repeat (8)
    begin
      pa = 4'(rnd());
      pb = rnd();
      pcp = rnd();
      op(0, mcsr_pkg::ADDR_PORT_A_DATA, {4'h0, pa});
      op(0, mcsr_pkg::ADDR_PORT_B_DATA, pb);
      op(0, mcsr_pkg::ADDR_PORT_C_DATA, pcp);
      op(1, mcsr_pkg::ADDR_PORT_A_DATA, pb);
      op(1, mcsr_pkg::ADDR_PORT_B_DATA, pcp);
      chk(pa_lat, {4'h0, pb[3:0]});
      op(1, mcsr_pkg::ADDR_PORT_C_DATA, pb);
      chk(pb_lat, pcp);
      nop();
      chk(pc_lat, pb);
    end
    op(1, mcsr_pkg::ADDR_PWR, 8'hff);
    op(1, mcsr_pkg::ADDR_WAKE, 8'hff);
    op(0, mcsr_pkg::ADDR_PWR, 8'hf0);
    chk({wdt_en, lvd_en, roc_en, irq_lvl}, {3'b111, pb[0]});
    chk(wake, 8'hfe);
    op(1, mcsr_pkg::ADDR_PWR, 8'h00);
    nop();
    chk({wdt_en, irq_lvl, wake}, 10'h0ff);
    $display("Ports and power control done");
    ctl(4'h0, 7'h08);
    op(1, mcsr_pkg::ADDR_TIMER, 8'hfd);
    chk(wdt_tick, 1'b1);
    wait_tof();
    chk(tof, 1'b1);
    repeat (3) nop();
    chk(tof, 1'b1);
    ctl(4'h0, 7'h28);
    ctl(4'h1, 7'h00);
    op(1, mcsr_pkg::ADDR_TIMER, 8'hff);
    repeat (4) nop();
    chk(tof, 1'b0);
    ext_pin = 1'b1;
    wait_tof();
    chk(tof, 1'b1);
    ctl(4'h1, 7'h38);
    op(1, mcsr_pkg::ADDR_TIMER, 8'hff);
    nop();
    chk(tof, 1'b0);
    ext_pin = 1'b0;
    wait_tof();
    chk(tof, 1'b1);
    // Prescaler on the timer halves the count rate at rate code zero
    ctl(4'h1, 7'h40);
    op(1, mcsr_pkg::ADDR_TIMER, 8'hfe);
    repeat (3) nop();
    chk({tof, wdt_tick}, 2'b00);
    wait_tof();
    chk(tof, 1'b1);
    $display("Timer done");
    tally_and_finish();
  end
endmodule : mcsr_bank_bench
